// ===== hdl/css_cfg.svh
// Constants of the coordinator startup sequencer: offsets, fields, resets, timing
`ifndef CSS_CFG_SVH
`define CSS_CFG_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define CSS_REG_CTRL      4'h0
`define CSS_REG_PAN       4'h1
`define CSS_REG_LANE      4'h2
`define CSS_REG_SHORT     4'h3
`define CSS_REG_RETENTION 4'h4
`define CSS_REG_TBS       4'h5
`define CSS_REG_DWELL     4'h6
`define CSS_REG_STATUS    4'h7

// ------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------
`define CSS_CTRL_ROLE     0
`define CSS_CTRL_ENP_LO   4
`define CSS_CTRL_ENP_HI   6
`define CSS_CTRL_CJP_LO   8
`define CSS_CTRL_CJP_HI   10
`define CSS_CJP_PICK_NET  0
`define CSS_CJP_PICK_LANE 1
`define CSS_CJP_ACCEPT    2
`define CSS_ENP_ANY_NET   0
`define CSS_ENP_ANY_LANE  1
`define CSS_ENP_AUTO      2

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define CSS_RST_ROLE      1'h0
`define CSS_RST_ENP       3'h0
`define CSS_RST_CJP       3'h0
`define CSS_RST_PAN       16'h1234
`define CSS_RST_LANE      8'h0C
`define CSS_RST_SHORT     16'h0000
`define CSS_RST_RETENTION 16'h0000
`define CSS_RST_TBS       16'h0001
`define CSS_RST_DWELL     16'h0004

// ------------------------------------------------------------
// Radio lanes, networks and timing
// ------------------------------------------------------------
`define CSS_LANE_FIRST    8'h0B
`define CSS_LANE_LAST     8'h1A
`define CSS_NET_BCAST     16'hFFFF
`define CSS_MAX_NETS      5
`define CSS_CLK_HZ        50000000
`define CSS_DWELL_UNIT_US 1000
`define CSS_RET_UNIT_US   10000
`define CSS_LED_HALF_US   500000

`endif

// ===== hdl/css_pkg.sv
// Types of the coordinator startup sequencer
package css_pkg;

  typedef enum logic [3:0] {
    CSS_IDLE,
    CSS_A_REQ,
    CSS_A_LISTEN,
    CSS_PICK,
    CSS_E_REQ,
    CSS_E_LISTEN,
    CSS_E_END,
    CSS_START,
    CSS_RUN
  } css_state_t;

endpackage

// ===== hdl/css_scan_if.sv
// Link between the sequencer and its table of networks found by the active scan
`timescale 1ns/1ps
interface css_scan_if;
  logic        clear;
  logic        add;
  logic [15:0] add_pan;
  logic [3:0]  add_lane;
  logic [15:0] query;
  logic        hit;
  logic        full;
  logic [2:0]  count;
  logic [15:0] lane_used;

  modport owner (input clear, add, add_pan, add_lane, query,
                 output hit, full, count, lane_used);
  modport user  (output clear, add, add_pan, add_lane, query,
                 input hit, full, count, lane_used);
endinterface

// ===== hdl/css_timer.sv
// Down counter that times one interval and pulses at its end
`timescale 1ns/1ps
module css_timer
(
  input  wire logic        clk,    // Module clock
  input  wire logic        resetn, // Synchronous reset, active low
  input  wire logic        ce,     // Clock enable
  input  wire logic        start,  // Load len and run
  input  wire logic        stop,   // Abandon the interval
  input  wire logic [31:0] len,    // Interval in cycles
  output logic             busy,   // Interval running
  output logic             done    // One-cycle pulse at the end
);
  logic [31:0] cnt;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      cnt  <= 32'h0;
      busy <= 1'b0;
      done <= 1'b0;
    end
    else if (ce)
    begin
      done <= 1'b0;
      if (stop)
        busy <= 1'b0;
      else if (start)
      begin
        cnt  <= (len == 32'h0) ? 32'h1 : len;
        busy <= 1'b1;
      end
      else if (busy)
      begin
        if (cnt == 32'h1)
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        else
          cnt <= cnt - 32'h1;
      end
    end
  end
endmodule

// ===== hdl/css_scan_table.sv
// Table of distinct networks found by the active scan
`timescale 1ns/1ps
`include "css_cfg.svh"
module css_scan_table
(
  input  wire logic clk,    // Module clock
  input  wire logic resetn, // Synchronous reset, active low
  input  wire logic ce,     // Clock enable
  css_scan_if.owner sb      // Sequencer side
);
  localparam int N = `CSS_MAX_NETS;

  logic [15:0] pan_q  [N];
  logic [3:0]  lane_q [N];
  logic [N-1:0] vld;
  logic [N-1:0] qhit;
  logic [N-1:0] ahit;
  logic [2:0]   cnt;
  logic [15:0]  used;

  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_cmp
      assign qhit[i] = vld[i] && (pan_q[i] == sb.query);
      assign ahit[i] = vld[i] && (pan_q[i] == sb.add_pan);
    end
  endgenerate

  always_comb
  begin
    used = 16'h0;
    for (int k = 0; k < N; k++)
      if (vld[k])
        used[lane_q[k]] = 1'b1;
  end

  assign sb.hit       = |qhit;
  assign sb.full      = &vld;
  assign sb.count     = cnt;
  assign sb.lane_used = used;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      vld <= '0;
      cnt <= 3'h0;
    end
    else if (ce)
    begin
      if (sb.clear)
      begin
        vld <= '0;
        cnt <= 3'h0;
      end
      else if (sb.add && !(|ahit) && !sb.full)
      begin
        vld[cnt]    <= 1'b1;
        pan_q[cnt]  <= sb.add_pan;
        lane_q[cnt] <= sb.add_lane;
        cnt         <= cnt + 3'h1;
      end
    end
  end
endmodule

// ===== hdl/css_top.sv
// Coordinator startup sequencer: role, scans, network start, joins, LED, retention
//
// How it works
// - Role select 1 makes a coordinator, 0 an end device; end device after reset.
// - Retention zero sends at once; else a coordinator holds data for the period, then discards it; an end device sends at once.
// - Pick-network bit set: active scan, beacon request per lane, listen one dwell.
// - Scan walks every lane or stops at five distinct networks, recording each.
// - Own network number kept unless found; otherwise an unused number replaces it.
// - Pick-network bit clear: no active scan, network number kept.
// - Pick-lane bit set: energy scan each lane one dwell, keeping peak energy.
// - Quietest lane is chosen, lanes of found networks excluded.
// - Pick-lane bit clear: no energy scan, lane kept.
// - Network step, then lane step, then start on the result.
// - Joins accepted only while the accept-joins flag is set.
// - LED solid until started, then blinks once per second.
// - Change of pick bits, network, lane or short address restarts.
// - Accept-joins change alone takes effect without restart.
// - Restart sends nothing to previously joined end devices.
// - End-node join policy tells whether address, network, lane may be taken.
// - End-node bit 2 enables joining, bit 0 any network, bit 1 any lane.
`timescale 1ns/1ps
`include "css_cfg.svh"
module css_top
#(
  parameter int DWELL_UNIT_CYC = `CSS_CLK_HZ / 1000000 * `CSS_DWELL_UNIT_US,
  parameter int RET_UNIT_CYC   = `CSS_CLK_HZ / 1000000 * `CSS_RET_UNIT_US,
  parameter int LED_HALF_CYC   = `CSS_CLK_HZ / 1000000 * `CSS_LED_HALF_US
)
(
  input  wire logic        clk,            // Module clock, 50 MHz
  input  wire logic        resetn,         // Synchronous reset, active low
  input  wire logic        ce,             // Clock enable, freezes all state
  input  wire logic [3:0]  addr,           // Register address
  input  wire logic [31:0] wdata,          // Register write data
  input  wire logic        wr,             // Write strobe
  input  wire logic        rd,             // Read strobe
  output logic      [31:0] rdata,          // Read data, cycle after rd
  output logic             beacon_req,     // Send beacon request on scan_lane
  output logic             energy_meas,    // Measure energy on scan_lane
  output logic      [7:0]  scan_lane,      // Lane under scan
  input  wire logic        beacon_valid,   // Beacon heard
  input  wire logic [15:0] beacon_pan,     // Network number of the beacon
  input  wire logic        energy_valid,   // Energy sample present
  input  wire logic [7:0]  energy_level,   // Energy sample
  output logic             net_started,    // Coordinator running
  output logic      [15:0] op_pan,         // Operating network number
  output logic      [7:0]  op_lane,        // Operating lane
  output logic             accept_joins,   // Association requests accepted
  output logic             assoc_attempt,  // End node may try to join
  output logic             assoc_any_pan,  // End node may take any network
  output logic             assoc_any_lane, // End node may take any lane
  input  wire logic        msg_pending,    // Outgoing message offered
  input  wire logic        msg_poll,       // Destination polled for it
  output logic             tx_now,         // Send the message now, pulse
  output logic             msg_discard,    // Held message dropped, pulse
  output logic             msg_held,       // A message is being held
  output logic             assoc_led       // Association LED
);
  // ------------------------------------------------------------
  // Registers and state
  // ------------------------------------------------------------
  logic              role;
  logic [2:0]        enp;
  logic [2:0]        cjp;
  logic [15:0]       pan;
  logic [7:0]        lane;
  logic [15:0]       short_address;
  logic [15:0]       retention_period;
  logic [15:0]       time_before_sleep;
  logic [15:0]       scan_dwell;
  css_pkg::css_state_t state;
  logic              did_active;
  logic [15:0]       cand;
  logic [7:0]        emax;
  logic [7:0]        best_e;
  logic [3:0]        best_idx;
  logic              best_ok;
  logic [15:0]       snap_pan;
  logic [7:0]        snap_lane;
  logic [15:0]       snap_short;
  logic [1:0]        snap_pick;

  css_scan_if sb ();

  // ------------------------------------------------------------
  // Decode and selection
  // ------------------------------------------------------------
  wire        sel_ctrl  = wr && (addr == `CSS_REG_CTRL);
  wire        sel_pan   = wr && (addr == `CSS_REG_PAN);
  wire        sel_lane  = wr && (addr == `CSS_REG_LANE);
  wire [3:0]  lane_idx  = 4'(scan_lane - `CSS_LANE_FIRST);
  wire        last_lane = (scan_lane == `CSS_LANE_LAST);
  wire [31:0] dwell_len = 32'(scan_dwell) * 32'(DWELL_UNIT_CYC);
  wire [31:0] ret_len   = 32'(retention_period) * 32'(RET_UNIT_CYC);
  wire        running   = (state == css_pkg::CSS_RUN);
  wire        changed   = (pan != snap_pan) || (lane != snap_lane)
                       || (short_address != snap_short)
                       || (cjp[1:0] != snap_pick);
  wire        excluded  = did_active && sb.lane_used[lane_idx];
  wire        quieter   = !excluded && (!best_ok || emax < best_e);
  wire        dwell_go  = (state == css_pkg::CSS_A_REQ) || (state == css_pkg::CSS_E_REQ);
  wire        dwell_done;
  wire        dwell_stop = (state == css_pkg::CSS_A_LISTEN) && sb.full;
  wire        ret_done;
  wire        led_busy;
  wire        led_done;
  wire        ret_start = msg_pending && role && !msg_held && (retention_period != 16'h0);
  wire        ret_stop  = msg_held && msg_poll;
  wire [31:0] rd_mux    =
      (addr == `CSS_REG_CTRL)      ? {21'h0, cjp, 1'b0, enp, 3'h0, role} :
      (addr == `CSS_REG_PAN)       ? {16'h0, pan} :
      (addr == `CSS_REG_LANE)      ? {24'h0, lane} :
      (addr == `CSS_REG_SHORT)     ? {16'h0, short_address} :
      (addr == `CSS_REG_RETENTION) ? {16'h0, retention_period} :
      (addr == `CSS_REG_TBS)       ? {16'h0, time_before_sleep} :
      (addr == `CSS_REG_DWELL)     ? {16'h0, scan_dwell} :
      (addr == `CSS_REG_STATUS)    ? {23'h0, sb.count, net_started, 1'b0, state} :
                                     32'h0;

  assign beacon_req  = (state == css_pkg::CSS_A_REQ);
  assign energy_meas = (state == css_pkg::CSS_E_LISTEN);
  assign sb.clear    = (state == css_pkg::CSS_IDLE);
  assign sb.add      = (state == css_pkg::CSS_A_LISTEN) && beacon_valid;
  assign sb.add_pan  = beacon_pan;
  assign sb.add_lane = lane_idx;
  assign sb.query    = cand;

  // ------------------------------------------------------------
  // Timers and network table
  // ------------------------------------------------------------
  css_timer u_dwell (
    .clk(clk), .resetn(resetn), .ce(ce), .start(dwell_go), .stop(dwell_stop),
    .len(dwell_len), .busy(), .done(dwell_done));

  css_timer u_ret (
    .clk(clk), .resetn(resetn), .ce(ce), .start(ret_start), .stop(ret_stop),
    .len(ret_len), .busy(), .done(ret_done));

  css_timer u_led (
    .clk(clk), .resetn(resetn), .ce(ce), .start(running && !led_busy),
    .stop(!running), .len(32'(LED_HALF_CYC - 1)), .busy(led_busy), .done(led_done));

  css_scan_table u_table (.clk(clk), .resetn(resetn), .ce(ce), .sb(sb));

  // ------------------------------------------------------------
  // Register file and read port
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      role              <= `CSS_RST_ROLE;
      enp               <= `CSS_RST_ENP;
      cjp               <= `CSS_RST_CJP;
      short_address     <= `CSS_RST_SHORT;
      retention_period  <= `CSS_RST_RETENTION;
      time_before_sleep <= `CSS_RST_TBS;
      scan_dwell        <= `CSS_RST_DWELL;
      rdata             <= 32'h0;
    end
    else if (ce)
    begin
      rdata <= rd ? rd_mux : 32'h0;
      if (sel_ctrl)
      begin
        role <= wdata[`CSS_CTRL_ROLE];
        enp  <= wdata[`CSS_CTRL_ENP_HI:`CSS_CTRL_ENP_LO];
        cjp  <= wdata[`CSS_CTRL_CJP_HI:`CSS_CTRL_CJP_LO];
      end
      if (wr && addr == `CSS_REG_SHORT)
        short_address <= wdata[15:0];
      if (wr && addr == `CSS_REG_RETENTION)
        retention_period <= wdata[15:0];
      if (wr && addr == `CSS_REG_TBS)
        time_before_sleep <= wdata[15:0];
      if (wr && addr == `CSS_REG_DWELL)
        scan_dwell <= wdata[15:0];
    end
  end

  // ------------------------------------------------------------
  // Startup sequence
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state      <= css_pkg::CSS_IDLE;
      pan        <= `CSS_RST_PAN;
      lane       <= `CSS_RST_LANE;
      scan_lane  <= `CSS_LANE_FIRST;
      did_active <= 1'b0;
      cand       <= 16'h0;
      emax       <= 8'h0;
      best_e     <= 8'h0;
      best_idx   <= 4'h0;
      best_ok    <= 1'b0;
      snap_pan   <= 16'h0;
      snap_lane  <= 8'h0;
      snap_short <= 16'h0;
      snap_pick  <= 2'h0;
    end
    else if (ce)
    begin
      case (state)
        css_pkg::CSS_IDLE:
        begin
          scan_lane  <= `CSS_LANE_FIRST;
          did_active <= cjp[`CSS_CJP_PICK_NET];
          best_ok    <= 1'b0;
          cand       <= pan;
          if (role && cjp[`CSS_CJP_PICK_NET])
            state <= css_pkg::CSS_A_REQ;
          else if (role && cjp[`CSS_CJP_PICK_LANE])
            state <= css_pkg::CSS_E_REQ;
          else if (role)
            state <= css_pkg::CSS_START;
        end
        css_pkg::CSS_A_REQ:
          state <= css_pkg::CSS_A_LISTEN;
        css_pkg::CSS_A_LISTEN:
          if (sb.full)
            state <= css_pkg::CSS_PICK;
          else if (dwell_done)
          begin
            if (last_lane)
              state <= css_pkg::CSS_PICK;
            else
            begin
              scan_lane <= scan_lane + 8'h1;
              state     <= css_pkg::CSS_A_REQ;
            end
          end
        css_pkg::CSS_PICK:
          if (sb.hit || cand == `CSS_NET_BCAST)
            cand <= cand + 16'h1;
          else
          begin
            pan       <= cand;
            scan_lane <= `CSS_LANE_FIRST;
            state     <= cjp[`CSS_CJP_PICK_LANE] ? css_pkg::CSS_E_REQ
                                                 : css_pkg::CSS_START;
          end
        css_pkg::CSS_E_REQ:
        begin
          emax  <= 8'h0;
          state <= css_pkg::CSS_E_LISTEN;
        end
        css_pkg::CSS_E_LISTEN:
        begin
          if (energy_valid && energy_level > emax)
            emax <= energy_level;
          if (dwell_done)
          begin
            if (quieter)
            begin
              best_e   <= emax;
              best_idx <= lane_idx;
              best_ok  <= 1'b1;
            end
            if (last_lane)
              state <= css_pkg::CSS_E_END;
            else
            begin
              scan_lane <= scan_lane + 8'h1;
              state     <= css_pkg::CSS_E_REQ;
            end
          end
        end
        css_pkg::CSS_E_END:
        begin
          if (best_ok)
            lane <= `CSS_LANE_FIRST + {4'h0, best_idx};
          state <= css_pkg::CSS_START;
        end
        css_pkg::CSS_START:
        begin
          snap_pan   <= pan;
          snap_lane  <= lane;
          snap_short <= short_address;
          snap_pick  <= cjp[1:0];
          state      <= css_pkg::CSS_RUN;
        end
        css_pkg::CSS_RUN:
          // Restart is silent: nothing is sent to joined end devices
          if (!role || changed)
            state <= css_pkg::CSS_IDLE;
        default:
          state <= css_pkg::CSS_IDLE;
      endcase
      if (sel_pan)
        pan <= wdata[15:0];
      if (sel_lane)
        lane <= wdata[7:0];
    end
  end

  // ------------------------------------------------------------
  // Outputs: start status, joins, LED, retention
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      net_started    <= 1'b0;
      op_pan         <= 16'h0;
      op_lane        <= 8'h0;
      accept_joins   <= 1'b0;
      assoc_attempt  <= 1'b0;
      assoc_any_pan  <= 1'b0;
      assoc_any_lane <= 1'b0;
      assoc_led      <= 1'b1;
      tx_now         <= 1'b0;
      msg_discard    <= 1'b0;
      msg_held       <= 1'b0;
    end
    else if (ce)
    begin
      net_started    <= running;
      op_pan         <= pan;
      op_lane        <= lane;
      accept_joins   <= running && cjp[`CSS_CJP_ACCEPT];
      assoc_attempt  <= !role && enp[`CSS_ENP_AUTO];
      assoc_any_pan  <= !role && enp[`CSS_ENP_AUTO] && enp[`CSS_ENP_ANY_NET];
      assoc_any_lane <= !role && enp[`CSS_ENP_AUTO] && enp[`CSS_ENP_ANY_LANE];
      if (!running)
        assoc_led <= 1'b1;
      else if (led_done)
        assoc_led <= !assoc_led;
      tx_now      <= (msg_pending && !ret_start) || ret_stop;
      msg_discard <= ret_done && msg_held && !msg_poll;
      if (ret_start)
        msg_held <= 1'b1;
      else if (ret_stop || ret_done)
        msg_held <= 1'b0;
    end
  end
endmodule

// ===== tb/css_checker.sv
// Port assertions of the coordinator startup sequencer
`timescale 1ns/1ps
module css_checker
#(
  parameter int LED_HALF_CYC = 25000000
)
(
  input wire logic       clk,          // Clock
  input wire logic       resetn,       // Reset, active low
  input wire logic       beacon_req,   // Beacon request
  input wire logic       energy_meas,  // Energy scan
  input wire logic [7:0] scan_lane,    // Lane under scan
  input wire logic       net_started,  // Running
  input wire logic       accept_joins, // Joins accepted
  input wire logic       msg_pending,  // Message offered
  input wire logic       msg_poll,     // Poll
  input wire logic       tx_now,       // Send now
  input wire logic       msg_discard,  // Dropped
  input wire logic       msg_held,     // Held
  input wire logic       assoc_led     // LED
);
  // ----
  // Helpers
  // ----
  logic led_q;
  int   led_cnt;
  always_ff @(posedge clk)
  begin
    led_q <= assoc_led;
    if (!resetn || !net_started || led_q != assoc_led)
      led_cnt <= 0;
    else
      led_cnt <= led_cnt + 1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_poll_hit;
    msg_held && msg_poll;
  endsequence
  // ----
  // Assertions
  // ----
  led_solid_a: assert property (!net_started && !$past(net_started) |-> assoc_led)
    else $error("led not solid before start");
  led_period_a: assert property (led_cnt <= LED_HALF_CYC + 3)
    else $error("led blink too slow");
  joins_run_a: assert property ($rose(accept_joins) |-> ##[0:1] net_started)
    else $error("joins accepted while stopped");
  beacon_once_a: assert property (beacon_req |=> !beacon_req)
    else $error("beacon request longer than one cycle");
  scan_apart_a: assert property (!(beacon_req && energy_meas))
    else $error("both scans at once");
  run_quiet_a: assert property (net_started |-> !beacon_req && !energy_meas)
    else $error("scan while running");
  lane_range_a: assert property (scan_lane >= 8'h0B && scan_lane <= 8'h1A)
    else $error("scan lane out of range");
  tx_cause_a: assert property (tx_now |-> $past(msg_pending) || $past(msg_poll))
    else $error("send without cause");
  hold_cause_a: assert property ($rose(msg_held) |-> $past(msg_pending))
    else $error("hold without message");
  poll_send_a: assert property (s_poll_hit |=> tx_now && !msg_held)
    else $error("poll did not send");
  drop_end_a: assert property (msg_discard |-> $past(msg_held) && !msg_held)
    else $error("discard without hold");
endmodule
bind css_top css_checker #(.LED_HALF_CYC(LED_HALF_CYC)) css_checker_i (.clk, .resetn,
  .beacon_req, .energy_meas, .scan_lane, .net_started, .accept_joins, .msg_pending,
  .msg_poll, .tx_now, .msg_discard, .msg_held, .assoc_led);

// ===== tb/css_radio_model.sv
// Radio peers: networks on lanes 0x0B..0x0F and an energy level per lane
`timescale 1ns/1ps
module css_radio_model
(
  input  wire logic        clk,          // Clock
  input  wire logic        beacon_req,   // Beacon request
  input  wire logic        energy_meas,  // Energy scan
  input  wire logic [7:0]  scan_lane,    // Lane under scan
  output logic             beacon_valid, // Beacon heard
  output logic      [15:0] beacon_pan,   // Its network number
  output logic             energy_valid, // Sample present
  output logic      [7:0]  energy_level  // Sample
);
  logic       d1, d2;
  wire        late = scan_lane[0];
  wire  [7:0] lvl  = (scan_lane == 8'h0B) ? 8'h01 : (scan_lane == 8'h11) ? 8'h02 : 8'h40;
  initial {d1, d2, beacon_valid, energy_valid, beacon_pan, energy_level} = '0;
  always @(posedge clk)
  begin
    d1 <= beacon_req && scan_lane <= 8'h0F;
    d2 <= d1;
    // Odd lanes answer one cycle later; released lines show the inverse
    beacon_valid <= late ? d2 : d1;
    beacon_pan <= (late ? d2 : d1) ? 16'h1229 + {8'h00, scan_lane} : ~beacon_pan;
    energy_valid <= energy_meas;
    energy_level <= energy_meas ? lvl : ~energy_level;
  end
endmodule

// ===== tb/test_coordinator_startup_sequencer.sv
// Self-checking bench of the coordinator startup sequencer
`timescale 1ns/1ps
module test_coordinator_startup_sequencer;
  localparam int LH = 6;
  logic        clk, resetn, ce, wr, rd, msg_pending, msg_poll, beacon_req, energy_meas;
  logic        beacon_valid, energy_valid, net_started, accept_joins, assoc_attempt;
  logic        assoc_any_pan, assoc_any_lane, tx_now, msg_discard, msg_held, assoc_led;
  logic [3:0]  addr;
  logic [31:0] wdata, rdata;
  logic [7:0]  scan_lane, energy_level, op_lane;
  logic [15:0] beacon_pan, op_pan;
  int          err_total, cmp_count, nbeac, i;
  logic [31:0] rst_tab [9] = '{32'h0, 32'h1234, 32'hC, 32'h0, 32'h0, 32'h1, 32'h4, 32'h0, 32'h0};

  css_top #(.DWELL_UNIT_CYC(4), .RET_UNIT_CYC(8), .LED_HALF_CYC(LH)) css_top_i (.clk, .resetn,
    .ce, .addr, .wdata, .wr, .rd, .rdata, .beacon_req, .energy_meas, .scan_lane, .beacon_valid,
    .beacon_pan, .energy_valid, .energy_level, .net_started, .op_pan, .op_lane, .accept_joins,
    .assoc_attempt, .assoc_any_pan, .assoc_any_lane, .msg_pending, .msg_poll, .tx_now,
    .msg_discard, .msg_held, .assoc_led);
  css_radio_model css_radio_model_i (.clk, .beacon_req, .energy_meas, .scan_lane,
    .beacon_valid, .beacon_pan, .energy_valid, .energy_level);

  // ----
  // Tasks
  // ----
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      err_total++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_chk(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("register", rdata, e);
  endtask
  task pulse(input logic p, input logic q);
    @(posedge clk);
    msg_pending <= p; msg_poll <= q;
    @(posedge clk);
    msg_pending <= 1'b0; msg_poll <= 1'b0;
    #1;
  endtask
  task automatic wait_lv(input string n, ref logic s, input logic v, input int lim);
    for (int k = 0; k < lim && s !== v; k++)
    begin
      @(posedge clk);
      #1;
    end
    chk(n, 32'(s), 32'(v));
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ----
  // Stimulus
  // ----
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) if (beacon_req === 1'b1) nbeac++;
  initial
  begin
    #(20 * 20000);
    err_total++;
    final_report();
  end
  initial
  begin
    {resetn, wr, rd, msg_pending, msg_poll, addr, wdata} = '0;
    {ce, err_total, cmp_count, nbeac} = {1'b1, 96'h0};
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    for (i = 0; i < 9; i++) rd_chk(4'(i), rst_tab[i]);
    chk("led", 32'(assoc_led), 32'h1);
    wr_reg(4'h9, 32'hFF);
    rd_chk(4'h9, 32'h0);
    $display("test reset done");
    wr_reg(4'h0, 32'h70);
    repeat (2) @(posedge clk);
    #1 chk("policy", 32'({assoc_attempt, assoc_any_pan, assoc_any_lane, net_started}), 32'hE);
    wr_reg(4'h0, 32'h50);
    repeat (2) @(posedge clk);
    #1 chk("policy", 32'({assoc_attempt, assoc_any_pan, assoc_any_lane}), 32'h6);
    wr_reg(4'h0, 32'h0);
    repeat (2) @(posedge clk);
    #1 chk("peer", 32'({assoc_attempt, net_started}), 32'h0);
    $display("test end node done");
    wr_reg(4'h0, 32'h401);
    wait_lv("started", net_started, 1'b1, 50);
    chk("pan", 32'(op_pan), 32'h1234);
    chk("lane", 32'(op_lane), 32'hC);
    chk("beacons", 32'(nbeac), 32'h0);
    chk("joins", 32'(accept_joins), 32'h1);
    chk("assoc", 32'(assoc_attempt), 32'h0);
    wait_lv("led", assoc_led, 1'b0, 3 * LH);
    wr_reg(4'h0, 32'h001);
    repeat (2) @(posedge clk);
    #1 chk("joins", 32'({accept_joins, net_started}), 32'h1);
    $display("test plain start done");
    nbeac = 0;
    wr_reg(4'h0, 32'h701);
    wait_lv("stopped", net_started, 1'b0, 5);
    wait_lv("started", net_started, 1'b1, 3000);
    chk("pan", 32'(op_pan), 32'h1239);
    chk("lane", 32'(op_lane), 32'h11);
    chk("beacons", 32'(nbeac), 32'h5);
    rd_chk(4'h7, 32'h168);
    $display("test scans done");
    wr_reg(4'h4, 32'h1);
    wr_reg(4'h5, 32'h3);
    rd_chk(4'h5, 32'h3);
    pulse(1'b1, 1'b0);
    chk("held", 32'(msg_held), 32'h1);
    wait_lv("discard", msg_discard, 1'b1, 30);
    pulse(1'b1, 1'b0);
    pulse(1'b1, 1'b0);
    chk("direct", 32'({tx_now, msg_held}), 32'h3);
    pulse(1'b0, 1'b1);
    chk("sent", 32'({tx_now, msg_held}), 32'h2);
    wr_reg(4'h4, 32'h0);
    pulse(1'b1, 1'b0);
    chk("direct", 32'({tx_now, msg_held}), 32'h2);
    $display("test retention done");
    wr_reg(4'h3, 32'h5);
    wait_lv("stopped", net_started, 1'b0, 5);
    chk("led", 32'(assoc_led), 32'h1);
    wait_lv("started", net_started, 1'b1, 3000);
    chk("pan", 32'(op_pan), 32'h1239);
    $display("test restart done");
    final_report();
  end
endmodule
